// ---- include/lsq_defines.svh ----
// Timing and threshold constants for the LED switch sequencer
// Functional notes
// RL1 - Supply start: precharge compensation, gate held off
// RL2 - Compensation above 0.8V: settled, gate enabled
// RL3 - Supply below 7.2V: stop gate, wait
// RL4 - Lockout discharges compensation, clears settled state
// RL5 - Peak current reached: gate off immediately
// RL6 - Gate stays off minimum off interval
// RL7 - Early aux fall: turn on at interval end
// RL8 - Late aux fall: turn on same cycle
// RL9 - Maximum off time forces new on-time
// RL10 - Sample aux once, blanking after turn-off
// RL11 - Aux above 3.2V thrice: latch fault
// RL12 - Supply above 24V thrice: latch fault
// RL13 - Over-voltage fault holds until lockout, restart
// RL14 - Aux below 400mV 5-10ms: short fault
// RL15 - Short fault restarts only after lockout
// RL16 - Short fault and restart repeat while persists
// RL17 - Current above 2.0V: gate off immediately
// RL18 - Blanking interval is 240 ns
// RL19 - Lockout clears both counters and short timer
// RL20 - Off and short times are cycle parameters
`ifndef LSQ_DEFINES_SVH
`define LSQ_DEFINES_SVH
`define LSQ_CLK_PERIOD_NS   10
`define LSQ_BLANK_NS        240
`define LSQ_BLANK_CYC       ((`LSQ_BLANK_NS + `LSQ_CLK_PERIOD_NS - 1) \
                             / `LSQ_CLK_PERIOD_NS)
`define LSQ_MIN_OFF_US      8
`define LSQ_MIN_OFF_CYC     ((`LSQ_MIN_OFF_US * 1000) / `LSQ_CLK_PERIOD_NS)
`define LSQ_MAX_OFF_CYC     4000
`define LSQ_SHORT_MS        5
`define LSQ_SHORT_CYC       ((`LSQ_SHORT_MS * 1000000) / `LSQ_CLK_PERIOD_NS)
`define LSQ_OV_LIMIT        3
`endif

// ---- include/lsq_pkg.sv ----
// Types for the LED switch sequencer
package lsq_pkg;
    typedef enum logic [3:0] {
        LSQ_WAIT   = 4'b0001,
        LSQ_CHARGE = 4'b0010,
        LSQ_RUN    = 4'b0100,
        LSQ_FAULT  = 4'b1000
    } lsq_state_e;

    typedef struct packed {
        logic supply_start;    // Supply above start level
        logic supply_low;      // Supply below lockout level
        logic supply_over;     // Supply above 24V
        logic comp_settled;    // Compensation above 0.8V
        logic peak_reached;    // Current at peak threshold
        logic over_current;    // Current above 2.0V
        logic aux_level;       // Aux winding sense above edge level
        logic aux_over;        // Aux above 3.2V
        logic aux_short;       // Aux below 400mV
    } lsq_sense_s;
endpackage

// ---- rtl/lsq_occ_counter.sv ----
// Saturating occurrence counter with latched trip
`timescale 1ns/1ps
module lsq_occ_counter
    import lsq_pkg::*;
#(
    parameter int LIMIT = 3
) (
    input  wire logic ref_clk, // Clock
    input  wire logic srst,    // Sync reset
    input  wire logic clear,   // Clear count
    input  wire logic hit,     // One occurrence
    output logic      trip     // Limit reached
);
    logic [3:0] count;

    always_ff @(posedge ref_clk) begin
        if (srst || clear) begin
            count <= 4'h0;
        end else if (hit && count < 4'(LIMIT)) begin
            count <= count + 4'h1;
        end
    end

    assign trip = (count >= 4'(LIMIT));
endmodule

// ---- rtl/lsq_short_timer.sv ----
// Continuous-condition qualification timer
`timescale 1ns/1ps
module lsq_short_timer
    import lsq_pkg::*;
#(
    parameter int CYCLES = 500000
) (
    input  wire logic ref_clk, // Clock
    input  wire logic srst,    // Sync reset
    input  wire logic clear,   // Clear timer
    input  wire logic sample,  // Sample strobe
    input  wire logic low,     // Sampled level low
    output logic      trip     // Qualified
);
    logic [31:0] count;
    logic        armed;

    // Time runs from the first low sample until a high sample clears it
    always_ff @(posedge ref_clk) begin
        if (srst || clear) begin
            count <= 32'h0000_0000;
        end else if (sample && !low) begin
            count <= 32'h0000_0000;
        end else if (armed && count < 32'(CYCLES)) begin
            count <= count + 32'h0000_0001;
        end
    end

    // Armed by a low sample, disarmed by a high one
    always_ff @(posedge ref_clk) begin
        if (srst || clear) begin
            armed <= 1'b0;
        end else if (sample) begin
            armed <= low;
        end
    end

    assign trip = armed && (count >= 32'(CYCLES));
endmodule

// ---- rtl/lsq_sequencer.sv ----
// LED converter switch and protection sequencer
`timescale 1ns/1ps
`include "lsq_defines.svh"
module lsq_sequencer
    import lsq_pkg::*;
#(
    parameter int MIN_OFF_CYC = `LSQ_MIN_OFF_CYC, // [RL20]
    parameter int MAX_OFF_CYC = `LSQ_MAX_OFF_CYC,
    parameter int SHORT_CYC   = `LSQ_SHORT_CYC,
    parameter int BLANK_CYC   = `LSQ_BLANK_CYC
) (
    input  wire logic       ref_clk,      // 100 MHz clock
    input  wire logic       srst,         // Sync reset, high
    input  wire lsq_sense_s sense,        // Comparator levels
    output logic            gate_on,      // Power switch gate
    output logic            comp_charge,  // Precharge compensation
    output logic            comp_dump,    // Discharge compensation
    output logic            loop_settled, // Loop settled
    output logic            fault_ovp_out,// Output over-voltage
    output logic            fault_ovp_sup,// Supply over-voltage
    output logic            fault_short   // Short-circuit fault
);
    lsq_state_e state;
    lsq_state_e next_state;
    logic [31:0] off_cnt;
    logic        aux_prev;
    logic        edge_seen;
    logic        sampled;
    logic        sample_stb;
    logic        aux_fall;
    logic        turn_off;
    logic        turn_on;
    logic        trip_ovo;
    logic        trip_ovs;
    logic        trip_sc;
    logic        lockout;
    logic        sup_prev;

    ////////////////////////////////////////////////////////////////////
    // Combinational decisions
    assign lockout  = sense.supply_low;
    assign aux_fall = aux_prev && !sense.aux_level;
    assign turn_off = gate_on
                      && (sense.peak_reached     // [RL5]
                          || sense.over_current); // [RL17]
    assign sample_stb = !gate_on && !sampled
                        && off_cnt == 32'(BLANK_CYC); // [RL10] [RL18]

    always_comb begin
        turn_on = 1'b0;
        if (state == LSQ_RUN && !gate_on
            && off_cnt >= 32'(MIN_OFF_CYC)) begin // [RL6]
            if (off_cnt == 32'(MIN_OFF_CYC) && edge_seen)
                turn_on = 1'b1;                    // [RL7]
            else if (aux_fall)
                turn_on = 1'b1;                    // [RL8]
            else if (off_cnt >= 32'(MAX_OFF_CYC))
                turn_on = 1'b1;                    // [RL9]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            LSQ_WAIT: begin
                if (sense.supply_start && !lockout)
                    next_state = LSQ_CHARGE;       // [RL1]
            end
            LSQ_CHARGE: begin
                if (lockout)
                    next_state = LSQ_WAIT;
                else if (sense.comp_settled)
                    next_state = LSQ_RUN;          // [RL2]
            end
            LSQ_RUN: begin
                if (lockout)
                    next_state = LSQ_WAIT;         // [RL3]
                else if (trip_ovo || trip_ovs || trip_sc)
                    next_state = LSQ_FAULT;
            end
            LSQ_FAULT: begin
                if (lockout)
                    next_state = LSQ_WAIT;         // [RL13] [RL15] [RL16]
            end
            default: next_state = LSQ_WAIT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk) begin
        if (srst)
            state <= LSQ_WAIT;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////
    // Gate drive
    always_ff @(posedge ref_clk) begin
        if (srst)
            gate_on <= 1'b0;
        else if (next_state != LSQ_RUN || turn_off)
            gate_on <= 1'b0;                       // [RL3] [RL5] [RL17]
        else if (turn_on)
            gate_on <= 1'b1;
    end

    // Off-time counter, restarts at every turn-off
    always_ff @(posedge ref_clk) begin
        if (srst || gate_on)
            off_cnt <= 32'h0000_0000;
        else if (off_cnt != 32'hFFFF_FFFF)
            off_cnt <= off_cnt + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            aux_prev <= 1'b0;
        else
            aux_prev <= sense.aux_level;
    end

    // Early falling edge remembered for interval end
    always_ff @(posedge ref_clk) begin
        if (srst || gate_on)
            edge_seen <= 1'b0;
        else if (aux_fall && off_cnt < 32'(MIN_OFF_CYC))
            edge_seen <= 1'b1;                     // [RL7]
    end

    always_ff @(posedge ref_clk) begin
        if (srst || gate_on)
            sampled <= 1'b0;
        else if (sample_stb)
            sampled <= 1'b1;                       // [RL10]
    end

    ////////////////////////////////////////////////////////////////////
    // Compensation node control
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            comp_charge  <= 1'b0;
            comp_dump    <= 1'b1;
            loop_settled <= 1'b0;
        end else begin
            comp_charge  <= (next_state == LSQ_CHARGE); // [RL1]
            comp_dump    <= (next_state == LSQ_WAIT);   // [RL4]
            loop_settled <= (next_state == LSQ_RUN)
                            || (next_state == LSQ_FAULT); // [RL2] [RL4]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Protection counters
    always_ff @(posedge ref_clk) begin
        if (srst)
            sup_prev <= 1'b0;
        else
            sup_prev <= sense.supply_over;
    end

    lsq_occ_counter #(.LIMIT(`LSQ_OV_LIMIT)) u_ov_out (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clear   (lockout),                        // [RL19]
        .hit     (sample_stb && sense.aux_over),   // [RL11]
        .trip    (trip_ovo)
    );

    lsq_occ_counter #(.LIMIT(`LSQ_OV_LIMIT)) u_ov_sup (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clear   (lockout),                        // [RL19]
        .hit     (sense.supply_over && !sup_prev), // [RL12]
        .trip    (trip_ovs)
    );

    lsq_short_timer #(.CYCLES(SHORT_CYC)) u_short (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clear   (lockout || state != LSQ_RUN),    // [RL19]
        .sample  (sample_stb),
        .low     (sense.aux_short),                // [RL14]
        .trip    (trip_sc)
    );

    always_ff @(posedge ref_clk) begin
        if (srst || lockout) begin
            fault_ovp_out <= 1'b0;
            fault_ovp_sup <= 1'b0;
            fault_short   <= 1'b0;
        end else if (state == LSQ_RUN) begin
            fault_ovp_out <= fault_ovp_out | trip_ovo; // [RL11]
            fault_ovp_sup <= fault_ovp_sup | trip_ovs; // [RL12]
            fault_short   <= fault_short | trip_sc;    // [RL14]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Named steps of start-up and fault shutdown
    sequence s_start_seen;
        state == LSQ_WAIT && sense.supply_start && !lockout;
    endsequence
    sequence s_precharging;
        comp_charge && !gate_on && !loop_settled;
    endsequence
    sequence s_settle_seen;
        state == LSQ_CHARGE && sense.comp_settled && !lockout;
    endsequence
    sequence s_settled;
        loop_settled && !comp_charge && !comp_dump;
    endsequence
    sequence s_trip_seen;
        state == LSQ_RUN && !lockout && (trip_ovo || trip_ovs || trip_sc);
    endsequence
    sequence s_switch_stopped;
        state == LSQ_FAULT && !gate_on;
    endsequence

    a_gate_peak_off: assert property ( // [RL5]
        gate_on && sense.peak_reached |=> !gate_on)
        else $error("gate stayed on at peak");
    a_gate_oc_off: assert property ( // [RL17]
        gate_on && sense.over_current |=> !gate_on)
        else $error("gate stayed on at over-current");
    a_min_off_hold: assert property ( // [RL6]
        $rose(gate_on) |-> $past(off_cnt) >= 32'(MIN_OFF_CYC))
        else $error("gate on before minimum off");
    a_lockout_stop: assert property ( // [RL3]
        lockout |=> !gate_on && comp_dump && !loop_settled)
        else $error("lockout did not stop switching");
    a_wait_no_gate: assert property ( // [RL1]
        state != LSQ_RUN |-> !gate_on)
        else $error("gate on outside run");
    a_fault_hold: assert property ( // [RL13]
        state == LSQ_FAULT && !lockout |=> state == LSQ_FAULT)
        else $error("fault released without lockout");
    a_late_edge_on: assert property ( // [RL8]
        state == LSQ_RUN && next_state == LSQ_RUN && !gate_on
        && aux_fall && off_cnt > 32'(MIN_OFF_CYC) && !turn_off
        |=> gate_on)
        else $error("late edge did not turn gate on");
    // Sample lands one blanking interval after the gate falls
    a_sample_time: assert property ( // [RL10] [RL18]
        $fell(gate_on) |-> ##BLANK_CYC sample_stb)
        else $error("aux sample at wrong time");
    a_start_charge: assert property ( // [RL1]
        s_start_seen |=> s_precharging)
        else $error("start did not precharge");
    a_settle_run: assert property ( // [RL2]
        s_settle_seen |=> s_settled)
        else $error("settle did not enter run");
    a_gate_needs_loop: assert property ( // [RL2]
        gate_on |-> loop_settled)
        else $error("gate on before loop settled");
    a_comp_exclusive: assert property ( // [RL4]
        !(comp_charge && comp_dump))
        else $error("charge and discharge together");
    a_trip_stop: assert property ( // [RL11] [RL12] [RL14]
        s_trip_seen |=> s_switch_stopped)
        else $error("fault did not stop switching");
    a_ovp_out_latch: assert property ( // [RL11]
        state == LSQ_RUN && !lockout && trip_ovo |=> fault_ovp_out)
        else $error("output over-voltage not latched");
    a_ovp_sup_latch: assert property ( // [RL12]
        state == LSQ_RUN && !lockout && trip_ovs |=> fault_ovp_sup)
        else $error("supply over-voltage not latched");
    a_short_latch: assert property ( // [RL14]
        state == LSQ_RUN && !lockout && trip_sc |=> fault_short)
        else $error("short fault not latched");
    a_lockout_clear: assert property ( // [RL19]
        lockout |=> !trip_ovo && !trip_ovs && !trip_sc)
        else $error("lockout left a counter armed");
    a_early_edge_on: assert property ( // [RL7]
        state == LSQ_RUN && next_state == LSQ_RUN && !gate_on
        && edge_seen && off_cnt == 32'(MIN_OFF_CYC)
        |=> gate_on)
        else $error("early edge did not turn on at interval end");
    a_max_off_on: assert property ( // [RL9]
        state == LSQ_RUN && next_state == LSQ_RUN && !gate_on
        && off_cnt >= 32'(MAX_OFF_CYC)
        |=> gate_on)
        else $error("maximum off time did not restart");
endmodule

// ---- tb/lsq_analog_model.sv ----
// Comparator model of the converter around the sequencer
`timescale 1ns/1ps
module lsq_analog_model
    import lsq_pkg::*;
(
    input  wire logic ref_clk, // Clock
    input  wire logic gate_on, // Gate drive
    input  wire logic ovr,     // Force output over-voltage
    input  wire logic shrt,    // Force shorted output
    input  int        on_len,  // Cycles to peak current
    input  int        ring,    // Aux high cycles after off
    output logic      peak,    // Peak current reached
    output logic      aux,     // Aux winding level
    output logic      aux_ov,  // Aux above over level
    output logic      aux_lo   // Aux below short level
);
    int   cnt  = 0;
    logic prev = 1'b0;
    initial {peak, aux, aux_ov, aux_lo} = 4'h0;
    // Counts cycles since the last gate transition
    always @(posedge ref_clk) begin
        prev   <= gate_on;
        cnt    <= (prev != gate_on) ? 1 : cnt + 1;
        // Raised one edge early so the on-time is on_len cycles
        peak   <= gate_on && prev && cnt + 2 >= on_len;
        aux    <= !shrt && !gate_on && cnt < ring;
        aux_ov <= ovr && !gate_on;
        aux_lo <= shrt && !gate_on;
    end
endmodule

// ---- tb/led_driver_switch_sequencer_test.sv ----
// Self-checking bench for the LED switch sequencer
`timescale 1ns/1ps
module led_driver_switch_sequencer_test
    import lsq_pkg::*;
;
    localparam int MINO = 80;
    localparam int MAXO = 400;
    localparam int SHC  = 200;
    logic       ref_clk = 1'b0;
    logic       srst;
    logic       s_start, s_low, s_over, c_set, oc, ovr, shrt;
    logic       peak, aux, aux_ov, aux_lo, g_d = 1'b0;
    logic       gate_on, comp_charge, comp_dump, loop_settled;
    logic       fault_ovp_out, fault_ovp_sup, fault_short;
    lsq_sense_s sense;
    int         on_len, ring, num_errors = 0, checks = 0;
    int         run = 0, last_on = 0, last_off = 0, n_on = 0, cyc = 0;
    int         t0, n0, e;
    assign sense = '{s_start, s_low, s_over, c_set, peak, oc, aux,
                     aux_ov, aux_lo};
    always #5 ref_clk = ~ref_clk;
    lsq_sequencer #(.MIN_OFF_CYC(MINO), .MAX_OFF_CYC(MAXO),
        .SHORT_CYC(SHC), .BLANK_CYC(24)) dut_u (.ref_clk(ref_clk),
        .srst(srst), .sense(sense), .gate_on(gate_on),
        .comp_charge(comp_charge), .comp_dump(comp_dump),
        .loop_settled(loop_settled), .fault_ovp_out(fault_ovp_out),
        .fault_ovp_sup(fault_ovp_sup), .fault_short(fault_short));
    lsq_analog_model model_u (.ref_clk(ref_clk), .gate_on(gate_on),
        .ovr(ovr), .shrt(shrt), .on_len(on_len), .ring(ring),
        .peak(peak), .aux(aux), .aux_ov(aux_ov), .aux_lo(aux_lo));
    ////////////////////////////////////////////////////////////////////
    // Measures on and off run lengths, cuts a hang short
    always @(posedge ref_clk) begin
        g_d <= gate_on;
        cyc <= cyc + 1;
        if (gate_on !== g_d) begin
            if (g_d === 1'b1) last_on <= run;
            else begin
                last_off <= run;
                n_on     <= n_on + 1;
            end
            run <= 1;
        end else run <= run + 1;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, string s);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi,
                           string s);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[ERR] %0t %s got %0d", $time, s, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wait_on(input int n);
        int k;
        k = n_on + n;
        for (int i = 0; i < 3000 && n_on < k; i++) tick(1);
        #1;
    endtask
    function automatic int exp_off(input int r);
        if (r < MINO) return MINO;
        if (r < MAXO) return r;
        return MAXO;
    endfunction
    task automatic startup();
        tick(1);
        s_low   <= 1'b0;
        s_start <= 1'b1;
        c_set   <= 1'b0;
        tick(3);
        #1;
        chk_bit(comp_charge, 1'b1, "precharge");
        chk_bit(gate_on | loop_settled, 1'b0, "early gate");
        tick(1);
        c_set <= 1'b1;
        tick(3);
        #1;
        chk_bit(loop_settled, 1'b1, "settled");
        wait_on(1);
        chk_bit(gate_on, 1'b1, "switching");
        $display("test startup done");
    endtask
    task automatic lockout();
        tick(1);
        s_start <= 1'b0;
        s_low   <= 1'b1;
        tick(2);
        #1;
        chk_bit(gate_on | loop_settled, 1'b0, "lockout gate");
        chk_bit(comp_dump, 1'b1, "discharge");
        chk_bit(fault_ovp_out | fault_ovp_sup | fault_short, 1'b0,
                "faults kept");
        $display("test lockout done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {srst, s_low} = 2'b11;
        {s_start, s_over, c_set, oc, ovr, shrt} = 6'h00;
        on_len = 20;
        ring   = 30;
        void'($urandom(32'h9cee3c96));
        tick(16);
        srst <= 1'b0;
        tick(1);
        #1;
        chk_bit(comp_dump & ~gate_on, 1'b1, "reset state");
        startup();
        for (int k = 0; k < 12; k++) begin
            tick(1);
            on_len <= 8 + $urandom % 30;
            case (k % 3)
                0: ring <= (k == 0) ? MINO - 2 : 10 + $urandom % 60;
                1: ring <= (k == 1) ? MINO + 2 : MINO + 10 + $urandom % 250;
                default: ring <= 100000;
            endcase
            wait_on(3);
            e = exp_off(ring);
            chk_rng(last_off, e, e + 3, "off time");
            chk_rng(last_on, on_len, on_len + 3, "on time");
        end
        $display("test switching done");
        on_len <= 100000;
        tick(30);
        #1;
        chk_bit(gate_on, 1'b1, "on without peak");
        tick(2);
        oc <= 1'b1;
        tick(2);
        #1;
        chk_bit(gate_on, 1'b0, "over-current cut");
        tick(1);
        oc     <= 1'b0;
        on_len <= 20;
        ovr    <= 1'b1;
        n0 = n_on;
        for (int i = 0; i < 3000 && fault_ovp_out !== 1'b1; i++) tick(1);
        #1;
        chk_bit(fault_ovp_out, 1'b1, "output ovp");
        chk_rng(n_on - n0, 2, 3, "ovp samples");
        n0 = n_on;
        tick(600);
        chk_rng(n_on - n0, 0, 0, "ovp stops gate");
        ovr <= 1'b0;
        lockout();
        startup();
        for (int p = 0; p < 3; p++) begin
            s_over <= 1'b1;
            tick(5);
            s_over <= 1'b0;
            tick(20);
            #1;
            chk_bit(fault_ovp_sup, p == 2, "supply ovp");
            tick(1);
        end
        $display("test overvoltage done");
        lockout();
        startup();
        for (int r = 0; r < 2; r++) begin
            shrt <= 1'b1;
            t0 = cyc;
            for (int i = 0; i < 3000 && fault_short !== 1'b1; i++) tick(1);
            #1;
            chk_bit(fault_short, 1'b1, "short fault");
            chk_rng(cyc - t0, SHC, 2 * SHC + MAXO, "short time");
            chk_bit(gate_on, 1'b0, "short gate off");
            tick(300);
            #1;
            chk_bit(fault_short, 1'b1, "short holds");
            // Short removed so the restart reaches switching
            shrt <= 1'b0;
            lockout();
            startup();
        end
        $display("test short done");
        wrap_up();
    end
endmodule
